// [cfg_bars_map.svh]
`ifndef CFG_BARS_MAP_SVH
`define CFG_BARS_MAP_SVH
`define EXT_BASE_OFFSET      8'h14
`define CARD_BASE_OFFSET     8'h18
`define CARD_PTR_OFFSET      8'h28
`define EXT_BASE_RESET       18'h00000
`define CARD_BASE_RESET      21'h000000
`define EXT_PTR_LSB          14
`define CARD_PTR_LSB         11
`define STRAP_SETTLE_CYCLES  2'h1
`endif

// [cfg_bars_pkg.sv]
package cfg_bars_pkg;
    typedef enum logic [1:0]
    {
        ST_RESET  = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_RUN    = 2'b10
    } strap_state_type;
endpackage : cfg_bars_pkg

// [byte_lane_merge.sv]
`timescale 1ns/1ps
// merges write data into a stored word, only on enabled byte lanes
module byte_lane_merge
(
    input  wire logic [31:0] old_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  be_i,
    output logic      [31:0] new_o
);
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            new_o[i*8 +: 8] = be_i[i] ? wdata_i[i*8 +: 8] : old_i[i*8 +: 8];
        end
    end
endmodule : byte_lane_merge

// [ohci_function_config_bars.sv]
`timescale 1ns/1ps
`include "cfg_bars_map.svh"
module ohci_function_config_bars
    import cfg_bars_pkg::*;
(
    // clock and global reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // strap pin
    input  wire logic        pccard_mode_strap_i,
    // configuration access
    input  wire logic        cfg_rd_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic      [31:0] cfg_rdata_o,
    output logic             cfg_ack_o,
    // decoded region bases and card info lock flag for the memory decoder
    output logic      [31:0] ext_region_base_o,
    output logic      [31:0] card_info_base_o,
    output logic             card_info_locked_o
);
    logic [1:0]      strap_sync_q;
    logic            strap_locked_q;
    strap_state_type state_q;
    logic [17:0]     ext_region_pointer_q;
    logic [20:0]     card_info_base_field_q;
    logic [31:0]     ext_word;
    logic [31:0]     card_word;
    logic [31:0]     ext_merged;
    logic [31:0]     card_merged;
    logic [31:0]     rdata_d;
    logic            ext_hit;
    logic            card_hit;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction : hit

    assign ext_hit  = hit(cfg_addr_i, `EXT_BASE_OFFSET);
    assign card_hit = hit(cfg_addr_i, `CARD_BASE_OFFSET);

    // size, prefetch, type and space fields are constant zero
    assign ext_word  = {ext_region_pointer_q, 14'h0000};
    assign card_word = strap_locked_q ? 32'h00000000 : {card_info_base_field_q, 11'h000};

    byte_lane_merge u_ext_merge
    (
        .old_i   (ext_word),
        .wdata_i (cfg_wdata_i),
        .be_i    (cfg_be_i),
        .new_o   (ext_merged)
    );

    byte_lane_merge u_card_merge
    (
        .old_i   (card_word),
        .wdata_i (cfg_wdata_i),
        .be_i    (cfg_be_i),
        .new_o   (card_merged)
    );

    // strap is a pin: two flops before use
    // kept out of reset so the strap level is already through both flops at release;
    // clearing them would make the capture below always see zero
    always_ff @(posedge clk_i)
    begin
        strap_sync_q <= {strap_sync_q[0], pccard_mode_strap_i};
    end

    // strap captured once after global reset release, then held
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            state_q        <= ST_RESET;
            strap_locked_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_RESET:  state_q <= ST_SAMPLE;
                ST_SAMPLE:
                begin
                    strap_locked_q <= strap_sync_q[1];
                    state_q        <= ST_RUN;
                end
                ST_RUN:    state_q <= ST_RUN;
                default:   state_q <= ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            ext_region_pointer_q <= `EXT_BASE_RESET;
        else if (cfg_wr_i && ext_hit)
            ext_region_pointer_q <= ext_merged[31:`EXT_PTR_LSB];
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            card_info_base_field_q <= `CARD_BASE_RESET;
        else if (strap_locked_q)
            card_info_base_field_q <= `CARD_BASE_RESET;
        else if (cfg_wr_i && card_hit)
            card_info_base_field_q <= card_merged[31:`CARD_PTR_LSB];
    end

    // card info pointer and unmapped offsets read zero
    always_comb
    begin
        rdata_d = 32'h00000000;
        if (ext_hit)
            rdata_d = ext_word;
        else if (card_hit)
            rdata_d = card_word;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            cfg_rdata_o <= 32'h00000000;
            cfg_ack_o   <= 1'b0;
        end
        else
        begin
            cfg_ack_o   <= cfg_rd_i || cfg_wr_i;
            cfg_rdata_o <= cfg_rd_i ? rdata_d : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            ext_region_base_o  <= 32'h00000000;
            card_info_base_o   <= 32'h00000000;
            card_info_locked_o <= 1'b0;
        end
        else
        begin
            ext_region_base_o  <= ext_word;
            card_info_base_o   <= card_word;
            card_info_locked_o <= strap_locked_q;
        end
    end

    chk_ext_all_ones: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cfg_wr_i && ext_hit && cfg_be_i == 4'hF && cfg_wdata_i == 32'hFFFFFFFF && !cfg_rd_i
        ##1 !cfg_wr_i ##1 cfg_rd_i && ext_hit && !cfg_wr_i |=> cfg_rdata_o == 32'hFFFFC000)
        else $error("extension base did not read back FFFFC000");
    chk_ext_low_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ext_region_base_o[13:0] == 14'h0000)
        else $error("extension base low bits not zero");
    chk_card_lock_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        strap_locked_q && cfg_rd_i && card_hit |=> cfg_rdata_o == 32'h00000000)
        else $error("locked card info base read non-zero");
    chk_card_low_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        card_info_base_o[10:0] == 11'h000)
        else $error("card info low bits not zero");
    chk_ptr_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cfg_rd_i && cfg_addr_i[7:2] == 6'h0A |=> cfg_rdata_o == 32'h00000000)
        else $error("card info pointer read non-zero");
    chk_lane_keep: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cfg_wr_i && ext_hit && !cfg_be_i[3] |=> ext_region_pointer_q[17:10] == $past(ext_region_pointer_q[17:10]))
        else $error("disabled lane changed extension base");
    chk_strap_sample: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state_q == ST_SAMPLE |=> strap_locked_q == $past(strap_sync_q[1]))
        else $error("strap not captured");
    chk_ack_timing: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cfg_rd_i || cfg_wr_i) |=> cfg_ack_o)
        else $error("access not acknowledged");
    cov_ext_write: cover property (@(posedge clk_i) cfg_wr_i && ext_hit);
    cov_card_write: cover property (@(posedge clk_i) cfg_wr_i && card_hit && !strap_locked_q);
    cov_locked: cover property (@(posedge clk_i) strap_locked_q && cfg_rd_i && card_hit);
endmodule : ohci_function_config_bars

// [cfg_host_model.sv]
`timescale 1ns/1ps
module cfg_host_model
(
    // bus clock
    input  wire logic        clk_i,
    // answer from the device
    input  wire logic [31:0] cfg_rdata_i,
    input  wire logic        cfg_ack_i,
    // requests to the device
    output logic             cfg_rd_o,
    output logic             cfg_wr_o,
    output logic      [7:0]  cfg_addr_o,
    output logic      [3:0]  cfg_be_o,
    output logic      [31:0] cfg_wdata_o
);
    initial
    begin
        {cfg_rd_o, cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = '0;
    end
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                          output logic [31:0] rd, output logic ack);
        @(posedge clk_i);
        #1;
        {cfg_wr_o, cfg_rd_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {wr, !wr, a, be, wd};
        @(posedge clk_i);
        #1;
        rd = cfg_rdata_i;
        ack = cfg_ack_i;
        {cfg_wr_o, cfg_rd_o} = 2'b00;
        // address and write data lines toggle so a stale value is never mistaken for a live one
        cfg_addr_o = ~cfg_addr_o;
        cfg_wdata_o = ~cfg_wdata_o;
    endtask : access
endmodule : cfg_host_model

// [ohci_function_config_bars_tb.sv]
`timescale 1ns/1ps
module ohci_function_config_bars_tb;
    logic        clk_i = 1'b0, nrst_i = 1'b0, strap = 1'b1, rd_s, wr_s, ack_s, locked, ack;
    logic [7:0]  addr_s, a;
    logic [3:0]  be_s, be;
    logic [31:0] rdata_s, wdata_s, ext_s, card_s, wd, exp_ext, exp_card;
    int          fail_count = 0, checked = 0, cycles = 0;
    always #20 clk_i = ~clk_i;
    ohci_function_config_bars uut (.clk_i(clk_i), .nrst_i(nrst_i), .pccard_mode_strap_i(strap),
        .cfg_rd_i(rd_s), .cfg_wr_i(wr_s), .cfg_addr_i(addr_s), .cfg_be_i(be_s), .cfg_wdata_i(wdata_s),
        .cfg_rdata_o(rdata_s), .cfg_ack_o(ack_s), .ext_region_base_o(ext_s), .card_info_base_o(card_s),
        .card_info_locked_o(locked));
    cfg_host_model host (.clk_i(clk_i), .cfg_rdata_i(rdata_s), .cfg_ack_i(ack_s), .cfg_rd_o(rd_s),
        .cfg_wr_o(wr_s), .cfg_addr_o(addr_s), .cfg_be_o(be_s), .cfg_wdata_o(wdata_s));
    function automatic logic [31:0] merge(input logic [31:0] o, w, input logic [3:0] b, input logic [31:0] m);
        for (int i = 0; i < 4; i++)
            if (b[i]) o[8*i+:8] = w[8*i+:8];
        return o & m;
    endfunction : merge
    task automatic check(input logic [31:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [3:0] b, input logic [31:0] d, e);
        logic [31:0] r;
        host.access(w, ad, b, d, r, ack);
        check({31'h0, ack}, 32'h1);
        if (!w) check(r, e);
    endtask : xfer
    task automatic do_reset(input logic s);
        @(posedge clk_i);
        #1;
        {nrst_i, strap} = {1'b0, s};
        repeat (6) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        repeat (4) @(posedge clk_i);
    endtask : do_reset
    task report_and_stop;
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    initial
    begin
        void'($urandom(32'h4f48));
        do_reset(1'b1);
        xfer(1'b0, 8'h14, 4'h0, 32'h0, 32'h0);
        xfer(1'b0, 8'h18, 4'h0, 32'h0, 32'h0);
        check({31'h0, locked}, 32'h1);
        xfer(1'b1, 8'h14, 4'hF, 32'hFFFFFFFF, 32'h0);
        xfer(1'b0, 8'h14, 4'h0, 32'h0, 32'hFFFFC000);
        // base output trails the register by one flop, so look after the read
        check(ext_s, 32'hFFFFC000);
        for (int k = 0; k < 4; k++)
            xfer(1'b1, 8'h18, 4'h1 << k, 32'hFFFFFFFF, 32'h0);
        xfer(1'b0, 8'h18, 4'h0, 32'h0, 32'h0);
        xfer(1'b1, 8'h28, 4'hF, 32'hFFFFFFFF, 32'h0);
        xfer(1'b0, 8'h28, 4'h0, 32'h0, 32'h0);
        exp_ext = 32'hFFFFC000;
        repeat (40)
        begin
            wd = $urandom;
            be = 4'($urandom);
            a = ($urandom % 3 == 0) ? 8'h14 : {6'($urandom % 64), 2'b00};
            if (a == 8'h18) a = 8'h28;
            xfer(1'b1, a, be, wd, 32'h0);
            if (a == 8'h14) exp_ext = merge(exp_ext, wd, be, 32'hFFFFC000);
            xfer(1'b0, a, 4'h0, 32'h0, (a == 8'h14) ? exp_ext : 32'h0);
            check(ext_s, exp_ext);
        end
        do_reset(1'b0);
        xfer(1'b0, 8'h14, 4'h0, 32'h0, 32'h0);
        check({31'h0, locked}, 32'h0);
        exp_card = 32'h0;
        for (int k = 0; k < 4; k++)
        begin
            wd = $urandom;
            xfer(1'b1, 8'h18, 4'h1 << k, wd, 32'h0);
            exp_card = merge(exp_card, wd, 4'h1 << k, 32'hFFFFF800);
            xfer(1'b0, 8'h18, 4'h0, 32'h0, exp_card);
        end
        check(card_s, exp_card);
        report_and_stop();
    end
endmodule : ohci_function_config_bars_tb
